/* hw/relay_output_function_select.v */
/*
 Multi-function relay output selector: picks one drive status condition
 by function code and drives the board relay contact, with a register
 port and a level interrupt on relay edges.
 Assumes status inputs are synchronous to i_core_clk and already
 qualified by the drive's control core.
*/
`timescale 1ns/1ps
`include "relay_sel_defs.vh"

// Summary of operation
// - Code 0 keeps the relay off whatever the status.
// - Code 1 drives the relay while running, zero frequency included.
// - Code 2 drives the relay while a fault has stopped the drive.
// - Code 3 follows the first frequency level detect signal.
// - Code 4 follows the frequency reached signal.
// - Code 5 on only while running at zero frequency; off when stopped.
// - Code 6 follows the motor overload pre-alarm.
// - Code 7 follows the drive overload pre-alarm, ten seconds ahead.
// - Code 8 on when counter reaches the set count.
// - Code 9 on when counter reaches the designated count.
// - Code 10 on when actual length exceeds the length setting.
// - Code 11 holds the relay 250 ms from each program cycle done, restarting on a new one.
// - Code 12 on once cumulative run time passes its threshold.
// - Code 13 on when frequency is held at a limit.
// - Code 14 on while torque limited with stall protection active.
// - Code 15 on when supplies stable, no fault, drive operable.
// - Function code resets to 2, fault stop.
module relay_output_function_select #(
	parameter PULSE_CYCLES = `PULSE_CYCLES
) (
	// Clock and reset
	input  wire                 i_core_clk,
	input  wire                 i_rst_n,
	// Register port
	input  wire [`ADDR_W-1:0]   i_addr,
	input  wire [7:0]           i_wdata,
	input  wire                 i_wr,
	input  wire                 i_rd,
	output reg  [7:0]           o_rdata,
	// Drive status conditions
	input  wire                 i_running,
	input  wire                 i_fault_stop,
	input  wire                 i_freq_level_detect_one,
	input  wire                 i_freq_reached,
	input  wire                 i_zero_freq,
	input  wire                 i_motor_ol_prealarm,
	input  wire                 i_drive_ol_prealarm,
	input  wire                 i_set_count_reached,
	input  wire                 i_desig_count_reached,
	input  wire                 i_length_reached,
	input  wire                 i_sequence_program_done,
	input  wire                 i_run_time_reached,
	input  wire                 i_freq_limited,
	input  wire                 i_torque_limited,
	input  wire                 i_ready,
	// Relay and interrupt
	output reg                  o_board_relay_contact,
	output reg                  o_irq
);

	localparam CNT_W    = 32;
	localparam ST_W     = 2;
	// One-hot states of the program-cycle pulse
	localparam ST_IDLE  = 2'b01;
	localparam ST_PULSE = 2'b10;

	// Reset synchroniser
	reg                  rst_s1_reg;
	reg                  rst_s2_reg;
	wire                 rst_n;

	// Register port decode
	wire                 wr_func;
	wire                 wr_enable;
	wire                 wr_clear;
	reg  [7:0]           rdata_next;

	// Function code
	reg  [7:0]           func_code_reg;
	reg  [7:0]           func_code_next;

	// Program-cycle pulse
	reg  [ST_W-1:0]      pulse_state_reg;
	reg  [ST_W-1:0]      pulse_state_next;
	reg  [CNT_W-1:0]     pulse_cnt_reg;
	reg  [CNT_W-1:0]     pulse_cnt_next;
	reg                  done_d_reg;
	wire                 done_rise;
	wire                 pulse_active;
	wire [CNT_W-1:0]     cnt_one;
	wire [CNT_W-1:0]     cnt_load;

	// Relay selection
	reg                  relay_next;

	// Interrupt
	wire [`IRQ_W-1:0]    irq_event;
	reg  [`IRQ_W-1:0]    irq_status_reg;
	wire [`IRQ_W-1:0]    irq_status_next;
	reg  [`IRQ_W-1:0]    irq_enable_reg;
	reg  [`IRQ_W-1:0]    irq_enable_next;
	wire                 irq_next;
	genvar               gi;

	// Reset released through two flops
	always @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end
		else
		begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end
	assign rst_n = rst_s2_reg;

	// Register port decode
	assign wr_func   = i_wr && (i_addr == `OFS_FUNC_CODE);
	assign wr_enable = i_wr && (i_addr == `OFS_IRQ_ENABLE);
	assign wr_clear  = i_wr && (i_addr == `OFS_IRQ_CLEAR);

	// Any byte is kept; unsupported codes read back as written
	always @*
	begin
		func_code_next = func_code_reg;
		if (wr_func)
			func_code_next = i_wdata;
	end

	// Program-cycle pulse helpers
	assign cnt_one      = {{(CNT_W-1){1'b0}}, 1'b1};
	assign cnt_load     = PULSE_CYCLES;
	assign done_rise    = i_sequence_program_done & ~done_d_reg;
	assign pulse_active = (pulse_state_reg == ST_PULSE);

	// Runs under any code, so a code change shows a pulse in flight
	always @*
	begin
		pulse_state_next = pulse_state_reg;
		pulse_cnt_next   = pulse_cnt_reg;
		case (pulse_state_reg)
		ST_IDLE:
		begin
			if (done_rise)
			begin
				pulse_state_next = ST_PULSE;
				pulse_cnt_next   = cnt_load;
			end
		end
		ST_PULSE:
		begin
			if (done_rise)
			begin
				pulse_cnt_next = cnt_load;
			end
			else if (pulse_cnt_reg == cnt_one)
			begin
				pulse_state_next = ST_IDLE;
				pulse_cnt_next   = {CNT_W{1'b0}};
			end
			else
			begin
				pulse_cnt_next = pulse_cnt_reg - cnt_one;
			end
		end
		default:
		begin
			pulse_state_next = ST_IDLE;
			pulse_cnt_next   = {CNT_W{1'b0}};
		end
		endcase
	end

	// Relay selection; conditions are sampled every cycle
	always @*
	begin
		case (func_code_reg)
		`FC_NONE:
			relay_next = 1'b0;
		`FC_RUNNING:
			relay_next = i_running;
		`FC_FAULT_STOP:
			relay_next = i_fault_stop;
		`FC_FREQ_LEVEL:
			relay_next = i_freq_level_detect_one;
		`FC_FREQ_REACHED:
			relay_next = i_freq_reached;
		`FC_ZERO_SPEED:
			relay_next = i_running & i_zero_freq;
		`FC_MOTOR_OL:
			relay_next = i_motor_ol_prealarm;
		`FC_DRIVE_OL:
			relay_next = i_drive_ol_prealarm;
		`FC_SET_COUNT:
			relay_next = i_set_count_reached;
		`FC_DESIG_COUNT:
			relay_next = i_desig_count_reached;
		`FC_LENGTH:
			relay_next = i_length_reached;
		`FC_SEQ_DONE:
			relay_next = pulse_active;
		`FC_RUN_TIME:
			relay_next = i_run_time_reached;
		`FC_FREQ_LIMIT:
			relay_next = i_freq_limited;
		`FC_TORQUE_LIMIT:
			relay_next = i_torque_limited;
		`FC_READY:
			relay_next = i_ready & ~i_fault_stop;
		default:
			relay_next = 1'b0;
		endcase
	end

	// Relay edge events
	assign irq_event[`IRQ_RELAY_ON]  = relay_next & ~o_board_relay_contact;
	assign irq_event[`IRQ_RELAY_OFF] = ~relay_next & o_board_relay_contact;

	// Sticky status per bit; set wins over a same-cycle clear
	generate
		for (gi = 0; gi < `IRQ_W; gi = gi + 1)
		begin : g_irq
			assign irq_status_next[gi] = irq_event[gi] |
				(irq_status_reg[gi] & ~(wr_clear & i_wdata[gi]));
		end
	endgenerate

	// Enable register
	always @*
	begin
		irq_enable_next = irq_enable_reg;
		if (wr_enable)
			irq_enable_next = i_wdata[`IRQ_W-1:0];
	end

	// Line follows the stored status, not last cycle's copy
	assign irq_next = |(irq_status_next & irq_enable_reg);

	// Read data stand one cycle, zero otherwise
	always @*
	begin
		rdata_next = 8'h00;
		if (i_rd)
		begin
			case (i_addr)
			`OFS_FUNC_CODE:
				rdata_next = func_code_reg;
			`OFS_STATUS:
				rdata_next = {7'h00, o_board_relay_contact};
			`OFS_IRQ_STATUS:
				rdata_next = {6'h00, irq_status_reg};
			`OFS_IRQ_ENABLE:
				rdata_next = {6'h00, irq_enable_reg};
			default:
				rdata_next = 8'h00;
			endcase
		end
	end

	// Function code register
	always @(posedge i_core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			func_code_reg <= `FUNC_CODE_RESET;
		end
		else
		begin
			func_code_reg <= func_code_next;
		end
	end

	// Pulse state
	always @(posedge i_core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pulse_state_reg <= ST_IDLE;
		end
		else
		begin
			pulse_state_reg <= pulse_state_next;
		end
	end

	// Pulse counter
	always @(posedge i_core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pulse_cnt_reg <= {CNT_W{1'b0}};
		end
		else
		begin
			pulse_cnt_reg <= pulse_cnt_next;
		end
	end

	// Completion edge detector; idle level of the input is low
	always @(posedge i_core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			done_d_reg <= 1'b0;
		end
		else
		begin
			done_d_reg <= i_sequence_program_done;
		end
	end

	// Relay output
	always @(posedge i_core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_board_relay_contact <= 1'b0;
		end
		else
		begin
			o_board_relay_contact <= relay_next;
		end
	end

	// Interrupt status
	always @(posedge i_core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_status_reg <= {`IRQ_W{1'b0}};
		end
		else
		begin
			irq_status_reg <= irq_status_next;
		end
	end

	// Interrupt enable
	always @(posedge i_core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_enable_reg <= {`IRQ_W{1'b0}};
		end
		else
		begin
			irq_enable_reg <= irq_enable_next;
		end
	end

	// Interrupt line
	always @(posedge i_core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_irq <= 1'b0;
		end
		else
		begin
			o_irq <= irq_next;
		end
	end

	// Read data
	always @(posedge i_core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_rdata <= 8'h00;
		end
		else
		begin
			o_rdata <= rdata_next;
		end
	end

endmodule // relay_output_function_select

/* pkg/relay_sel_defs.vh */
/*
 Constants for the relay output function selector: register offsets,
 function codes, reset values and pulse timing.
 Assumes inclusion by bare name from design files under hw/.
*/
`ifndef RELAY_SEL_DEFS_VH
`define RELAY_SEL_DEFS_VH

`define CLK_FREQ_HZ        10000000
`define PULSE_TIME_MS      250
`define PULSE_CYCLES       ((`CLK_FREQ_HZ / 1000) * `PULSE_TIME_MS)

`define ADDR_W             4
`define OFS_FUNC_CODE      4'h0
`define OFS_STATUS         4'h1
`define OFS_IRQ_STATUS     4'h2
`define OFS_IRQ_ENABLE     4'h3
`define OFS_IRQ_CLEAR      4'h4

`define FUNC_CODE_RESET    8'h02

`define FC_NONE            8'h00
`define FC_RUNNING         8'h01
`define FC_FAULT_STOP      8'h02
`define FC_FREQ_LEVEL      8'h03
`define FC_FREQ_REACHED    8'h04
`define FC_ZERO_SPEED      8'h05
`define FC_MOTOR_OL        8'h06
`define FC_DRIVE_OL        8'h07
`define FC_SET_COUNT       8'h08
`define FC_DESIG_COUNT     8'h09
`define FC_LENGTH          8'h0A
`define FC_SEQ_DONE        8'h0B
`define FC_RUN_TIME        8'h0C
`define FC_FREQ_LIMIT      8'h0D
`define FC_TORQUE_LIMIT    8'h0E
`define FC_READY           8'h0F

`define IRQ_RELAY_ON       0
`define IRQ_RELAY_OFF      1
`define IRQ_W              2

`endif

/* test/relay_load.sv */
/* Load on the relay contact: a coil that follows the contact.
 Assumes a contact level in the core clock domain. */
`timescale 1ns/1ps
module relay_load (
	// Contact side
	input  wire  i_core_clk,
	input  wire  i_contact,
	// Load state
	output logic o_energised
);
	always @(posedge i_core_clk)
		o_energised <= i_contact;
endmodule // relay_load

/* test/relay_sel_chk.sv */
/* Assertions on the relay selector ports.
 Assumes bind to the selector top; code mirrored from offset 0 writes. */
`timescale 1ns/1ps
module relay_sel_chk (
	// Clock, reset, register port
	input wire       i_core_clk,
	input wire       i_rst_n,
	input wire [3:0] i_addr,
	input wire [7:0] i_wdata,
	input wire       i_wr,
	input wire       i_rd,
	input wire [7:0] o_rdata,
	// Status and relay
	input wire       i_running,
	input wire       i_fault_stop,
	input wire       i_zero_freq,
	input wire       i_freq_limited,
	input wire       i_ready,
	input wire       o_board_relay_contact
);
	logic [7:0] code;
	wire        r = o_board_relay_contact;
	always @(posedge i_core_clk or negedge i_rst_n)
		if (!i_rst_n)
			code <= 8'h02;
		else if (i_wr && i_addr == 4'h0)
			code <= i_wdata;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	off_code_a: assert property ((code == 8'h00 || code > 8'h0F) |=> !r)
		else $error("relay on for idle code");
	run_code_a: assert property (code == 8'h01 |=> r == $past(i_running))
		else $error("relay not following run");
	fault_code_a: assert property (code == 8'h02 |=> r == $past(i_fault_stop))
		else $error("relay not following fault");
	zero_code_a: assert property (code == 8'h05
		|=> r == $past(i_running && i_zero_freq))
		else $error("relay wrong for zero speed");
	limit_code_a: assert property (code == 8'h0D |=> r == $past(i_freq_limited))
		else $error("relay wrong for limit");
	ready_code_a: assert property (code == 8'h0F
		|=> r == $past(i_ready && !i_fault_stop))
		else $error("relay wrong for ready");
	code_read_a: assert property (i_rd && i_addr == 4'h0
		|=> o_rdata == $past(code))
		else $error("code readback wrong");
	rdata_idle_a: assert property (!i_rd |=> o_rdata == 8'h00)
		else $error("read data not idle");
	cover property (code == 8'h0B && r);
	cover property (code == 8'h05 && r);
	cover property (i_rd && i_addr == 4'h0);
endmodule // relay_sel_chk

/* test/testbench.sv */
/* Bench for the relay selector: code table, pulse, interrupt.
 Assumes selector, checker and load model are compiled with it. */
`timescale 1ns/1ps
module testbench;
	logic        clk, rst_n, wr, rd;
	logic [3:0]  addr;
	logic [7:0]  wd;
	logic [14:0] st;
	wire  [7:0]  rdata;
	wire         relay, irq, energised;
	int          n_mismatch, tests_run, k, n;
	relay_output_function_select #(.PULSE_CYCLES(8)) uut (
		.i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wd),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_running(st[0]),
		.i_fault_stop(st[1]), .i_freq_level_detect_one(st[2]),
		.i_freq_reached(st[3]), .i_zero_freq(st[4]),
		.i_motor_ol_prealarm(st[5]), .i_drive_ol_prealarm(st[6]),
		.i_set_count_reached(st[7]), .i_desig_count_reached(st[8]),
		.i_length_reached(st[9]), .i_sequence_program_done(st[10]),
		.i_run_time_reached(st[11]), .i_freq_limited(st[12]),
		.i_torque_limited(st[13]), .i_ready(st[14]),
		.o_board_relay_contact(relay), .o_irq(irq));
	relay_load load (.i_core_clk(clk), .i_contact(relay),
		.o_energised(energised));
	// Codes 1..14 map onto status bit code-1 except the special ones
	function logic ref_relay(input [7:0] c, input [14:0] s);
		case (c)
			8'h05: return s[0] & s[4];
			8'h0F: return s[14] & ~s[1];
			8'h00, 8'h0B: return 1'b0;
			default: return c < 8'h10 ? s[c - 1] : 1'b0;
		endcase
	endfunction
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr_reg(input [3:0] a, input [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd_chk(input [3:0] a, input [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("rdata", e, rdata);
	endtask
	task wrap_up;
		if (n_mismatch == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial
	begin
		#1_000_000;
		n_mismatch++;
		wrap_up;
	end
	initial
	begin
		{rst_n, wr, rd, addr, wd, st} = '0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd_chk(4'h0, 8'h02);
		rd_chk(4'h7, 8'h00);
		// Sequence-done bit masked: it would start pulses under any code
		for (int c = 0; c < 17; c++)
		begin
			if (c == 11)
				continue;
			wr_reg(4'h0, c[7:0]);
			for (k = 0; k < 30; k++)
			begin
				@(posedge clk) st <= ((15'h1 << (k % 15)) ^ {15{k > 14}}) & 15'h7BFF;
				repeat (2) @(posedge clk);
				#1 chk("relay", ref_relay(c[7:0], st), relay);
				chk("load", ref_relay(c[7:0], st), energised);
			end
		end
		st <= '0;
		wr_reg(4'h0, 8'h0B);
		@(posedge clk) st <= 15'h0400;
		n = 0;
		repeat (20) @(negedge clk) n += relay;
		chk("pulse", 8'h08, n[7:0]);
		wr_reg(4'h0, 8'h01);
		wr_reg(4'h4, 8'h03);
		wr_reg(4'h3, 8'h01);
		@(posedge clk) st <= 15'h0001;
		repeat (3) @(negedge clk);
		chk("irq", 8'h01, irq);
		rd_chk(4'h2, 8'h01);
		wr_reg(4'h3, 8'h00);
		repeat (2) @(negedge clk);
		chk("irq", 8'h00, irq);
		wr_reg(4'h3, 8'h01);
		repeat (2) @(negedge clk);
		chk("irq", 8'h01, irq);
		wr_reg(4'h4, 8'h01);
		repeat (2) @(negedge clk);
		chk("irq", 8'h00, irq);
		rd_chk(4'h1, 8'h01);
		rd_chk(4'h3, 8'h01);
		wrap_up;
	end
endmodule // testbench
bind relay_output_function_select relay_sel_chk chk (
	.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_running(i_running), .i_fault_stop(i_fault_stop),
	.i_zero_freq(i_zero_freq), .i_freq_limited(i_freq_limited),
	.i_ready(i_ready), .o_board_relay_contact(o_board_relay_contact));
